// ### core/ocr_pkg.sv
// Shared constants and types for the optical sensor command register slice.
// Assumes one system clock domain and an open-drain two-wire slave link.
package ocr_pkg;
    // Link address and register map
    localparam logic [6:0] OCR_DEV_ADDR = 7'h13;
    localparam logic [7:0] OCR_REG_CMD = 8'h80;
    localparam logic [7:0] OCR_REG_ID = 8'h81;
    localparam logic [7:0] OCR_REG_SPARE = 8'h82;
    localparam logic [7:0] OCR_REG_LED = 8'h83;
    localparam logic [7:0] OCR_REG_LIGHT_HI = 8'h85;
    localparam logic [7:0] OCR_REG_LIGHT_LO = 8'h86;
    localparam logic [7:0] OCR_REG_RANGE_HI = 8'h87;
    localparam logic [7:0] OCR_REG_RANGE_LO = 8'h88;
    localparam logic [7:0] OCR_RD_NONE = 8'h00;
    // Command register bit positions
    localparam int OCR_CMD_LOCK = 7;
    localparam int OCR_CMD_LIGHT_RDY = 6;
    localparam int OCR_CMD_RANGE_RDY = 5;
    localparam int OCR_CMD_LIGHT_GO = 4;
    localparam int OCR_CMD_RANGE_GO = 3;
    // Emitter drive field and bus byte length
    localparam logic [5:0] OCR_LED_RESET = 6'h02;
    localparam logic [5:0] OCR_LED_MAX = 6'h14;
    localparam logic [4:0] OCR_DRIVE_RESET = 5'h02;
    localparam logic [3:0] OCR_BITS_BYTE = 4'h8;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_WBYTE = 7'h08,
        ST_WACK = 7'h10,
        ST_RBYTE = 7'h20,
        ST_RACK = 7'h40
    } ocr_bus_st_t;

    // One conversion result from the measurement engine
    typedef struct packed {
        logic done;
        logic [15:0] data;
    } ocr_conv_res_t;

    typedef struct packed {
        ocr_bus_st_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic [7:0] ptr;
        logic sda_out;
        logic sda_oe_n;
        logic [5:0] led;
        logic [4:0] drive;
        logic light_busy;
        logic range_busy;
        logic light_rdy;
        logic range_rdy;
        logic [15:0] light_res;
        logic [15:0] range_res;
        logic [22:0] acc;
        logic [7:0] avg_left;
        logic [2:0] avg_sel;
        logic light_go;
        logic range_go;
    } ocr_state_t;

    localparam ocr_state_t OCR_STATE_RESET = '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1,
        sda_oe_n: 1'b1, led: OCR_LED_RESET, drive: OCR_DRIVE_RESET, default: '0};
endpackage : ocr_pkg

// ### core/ocr_cmd_regs.sv
// Command, status, identification and emitter drive registers behind a two-wire slave.
// Assumes scl/sda inputs already synchronous to sys_clk; pad resolves sda from sda_oe_n.
// What this block does
// - Light ready set on result, cleared reading 85h/86h
// - Range ready set on result, cleared reading 87h/88h
// - Light trigger starts conversion; result at 85h/86h
// - Averaging runs several conversions, stores mean only
// - Range trigger starts conversion; result at 87h/88h
// - Both triggers in one write run together
// - Identification register read-only, part and revision
// - Register 82h has no function
// - Emitter register sets proximity LED current
// - Drive field times 10 mA, range 0-20
// - Drive values above 20 clamp to 200 mA
// - Top two emitter bits are read-only trim tag
// - Command register at 80h: lock, ready, trigger bits
// - Slave answers at seven-bit address 13h
`timescale 1ns/10ps
`default_nettype none
module ocr_cmd_regs
    import ocr_pkg::*;
#(
    parameter logic [7:0] PART_REV = 8'hA3, // Arbitrary identification value
    parameter logic [1:0] TRIM_TAG = 2'h1 // Arbitrary trim program value
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [2:0] light_avg_sel,
    input wire ocr_pkg::ocr_conv_res_t light_conv,
    input wire ocr_pkg::ocr_conv_res_t range_conv,
    output logic light_conv_start,
    output logic range_conv_start,
    output logic [4:0] led_drive_code
);
    import ocr_pkg::*;

    ocr_state_t s;
    ocr_state_t n;
    logic rise, fall, start_c, stop_c;
    logic wr_en, load_rd, light_clr, range_clr, light_set, range_set;
    logic [7:0] rd;
    logic [22:0] light_sum;

    // Read data seen by the host for a given pointer
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input ocr_state_t v);
        case (p)
            OCR_REG_CMD: rd_byte = {1'b1, v.light_rdy, v.range_rdy, v.light_busy,
                                    v.range_busy, 3'h0};
            OCR_REG_ID: rd_byte = PART_REV;
            OCR_REG_LED: rd_byte = {TRIM_TAG, v.led};
            OCR_REG_LIGHT_HI: rd_byte = v.light_res[15:8];
            OCR_REG_LIGHT_LO: rd_byte = v.light_res[7:0];
            OCR_REG_RANGE_HI: rd_byte = v.range_res[15:8];
            OCR_REG_RANGE_LO: rd_byte = v.range_res[7:0];
            default: rd_byte = OCR_RD_NONE;
        endcase
    endfunction : rd_byte

    // Codes above the limit would overdrive the emitter, so hold them at the top step
    function automatic logic [4:0] clamp_drive(input logic [5:0] v);
        clamp_drive = (v > OCR_LED_MAX) ? OCR_LED_MAX[4:0] : v[4:0];
    endfunction : clamp_drive

    // Line edges and bus conditions from last sampled levels
    assign rise = scl_in & ~s.scl_q;
    assign fall = ~scl_in & s.scl_q;
    assign start_c = scl_in & s.scl_q & s.sda_q & ~sda_in;
    assign stop_c = scl_in & s.scl_q & ~s.sda_q & sda_in;
    assign light_sum = s.acc + {7'h00, light_conv.data};

    // Next state of slave, register file and measurement sequencing
    always_comb begin
        n = s;
        wr_en = 1'b0;
        load_rd = 1'b0;
        light_clr = 1'b0;
        range_clr = 1'b0;
        light_set = 1'b0;
        range_set = 1'b0;
        rd = OCR_RD_NONE;
        n.scl_q = scl_in;
        n.sda_q = sda_in;
        n.light_go = 1'b0;
        n.range_go = 1'b0;
        if (start_c) begin
            n.st = ST_ADDR;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            n.st = ST_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            case (s.st)
                ST_ADDR, ST_WBYTE: begin
                    if (rise) begin
                        n.sh = {s.sh[6:0], sda_in};
                        n.cnt = s.cnt + 4'h1;
                    end else if (fall && s.cnt == OCR_BITS_BYTE) begin
                        n.cnt = 4'h0;
                        if (s.st == ST_WBYTE) begin
                            if (s.first) begin
                                n.ptr = s.sh;
                            end else begin
                                wr_en = 1'b1;
                                n.ptr = s.ptr + 8'h01;
                            end
                            n.first = 1'b0;
                            n.sda_oe_n = 1'b0;
                            n.st = ST_WACK;
                        end else if (s.sh[7:1] == OCR_DEV_ADDR) begin
                            n.rw = s.sh[0];
                            n.first = 1'b1;
                            n.sda_oe_n = 1'b0;
                            n.st = ST_AACK;
                        end else begin
                            n.st = ST_IDLE; // Other slaves' traffic is ignored
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (fall) begin
                        if (s.st == ST_AACK && s.rw) begin
                            load_rd = 1'b1;
                        end else begin
                            n.sda_oe_n = 1'b1;
                            n.st = ST_WBYTE;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (fall) begin
                        if (s.cnt == OCR_BITS_BYTE) begin
                            n.sda_oe_n = 1'b1;
                            n.st = ST_RACK;
                        end else begin
                            n.sda_oe_n = s.sh[7];
                            n.sh = {s.sh[6:0], 1'b0};
                            n.cnt = s.cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (rise && sda_in) begin
                        n.st = ST_IDLE; // Master's not-acknowledge ends the read
                    end else if (fall) begin
                        load_rd = 1'b1;
                    end
                end
                default: n.st = ST_IDLE;
            endcase
        end
        // Byte load for a read; open drain releases the line for a one
        if (load_rd) begin
            rd = rd_byte(s.ptr, s);
            n.sda_oe_n = rd[7];
            n.sh = {rd[6:0], 1'b0};
            n.cnt = 4'h1;
            n.ptr = s.ptr + 8'h01;
            n.st = ST_RBYTE;
            light_clr = (s.ptr == OCR_REG_LIGHT_HI) || (s.ptr == OCR_REG_LIGHT_LO);
            range_clr = (s.ptr == OCR_REG_RANGE_HI) || (s.ptr == OCR_REG_RANGE_LO);
        end
        // Register writes; identification, spare and result bytes ignore them
        if (wr_en && s.ptr == OCR_REG_CMD) begin
            if (s.sh[OCR_CMD_LIGHT_GO] && !s.light_busy) begin
                n.light_busy = 1'b1;
                n.light_go = 1'b1;
                n.acc = 23'h000000;
                n.avg_sel = light_avg_sel;
                n.avg_left = 8'((9'h001 << light_avg_sel) - 9'h001);
            end
            if (s.sh[OCR_CMD_RANGE_GO] && !s.range_busy) begin
                n.range_busy = 1'b1;
                n.range_go = 1'b1;
            end
        end
        if (wr_en && s.ptr == OCR_REG_LED) begin
            n.led = s.sh[5:0];
            n.drive = clamp_drive(s.sh[5:0]);
        end
        // Averaged light sequence: only the final mean becomes visible
        if (s.light_busy && light_conv.done) begin
            if (s.avg_left == 8'h00) begin
                n.light_res = 16'(light_sum >> s.avg_sel);
                n.light_busy = 1'b0;
                light_set = 1'b1;
            end else begin
                n.acc = light_sum;
                n.avg_left = s.avg_left - 8'h01;
                n.light_go = 1'b1;
            end
        end
        if (s.range_busy && range_conv.done) begin
            n.range_res = range_conv.data;
            n.range_busy = 1'b0;
            range_set = 1'b1;
        end
        // A result landing with the read that clears the flag keeps it set
        n.light_rdy = light_set | (s.light_rdy & ~light_clr);
        n.range_rdy = range_set | (s.range_rdy & ~range_clr);
    end

    // All state in one register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s <= OCR_STATE_RESET;
        end else begin
            s <= n;
        end
    end

    assign sda_out = s.sda_out;
    assign sda_oe_n = s.sda_oe_n;
    assign light_conv_start = s.light_go;
    assign range_conv_start = s.range_go;
    assign led_drive_code = s.drive;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence seq_cmd_write;
        wr_en && s.ptr == OCR_REG_CMD;
    endsequence
    sequence seq_addr_hit;
        s.st == ST_ADDR && fall && s.cnt == OCR_BITS_BYTE && s.sh[7:1] == OCR_DEV_ADDR;
    endsequence

    a_light_rdy_set: assert property (light_set |=> s.light_rdy
        ##1 (s.light_rdy || $past(light_clr)))
        else $error("light ready not held after result");
    a_light_rdy_clr: assert property (light_clr && !light_set |=> !s.light_rdy)
        else $error("light ready not cleared by result read");
    a_range_rdy_clr: assert property (range_clr && !range_set |=> !s.range_rdy)
        else $error("range ready not cleared by result read");
    a_light_trigger: assert property (seq_cmd_write ##0 s.sh[4] && !s.light_busy
        |=> light_conv_start && s.light_busy)
        else $error("light trigger did not start conversion");
    a_both_trigger: assert property (seq_cmd_write ##0 s.sh[4] && s.sh[3] && !s.light_busy
        && !s.range_busy |=> light_conv_start && range_conv_start)
        else $error("joint trigger did not start both");
    a_avg_mean: assert property (s.light_busy && light_conv.done && s.avg_left == 8'h00
        |=> s.light_res == 16'($past(light_sum) >> $past(s.avg_sel)) && s.light_rdy)
        else $error("light result is not the mean");
    a_avg_repeat: assert property (s.light_busy && light_conv.done && s.avg_left != 8'h00
        |=> light_conv_start && s.light_busy && !$rose(s.light_rdy))
        else $error("averaging sequence stopped early");
    a_range_done: assert property (s.range_busy && range_conv.done
        |=> !s.range_busy && s.range_rdy && s.range_res == $past(range_conv.data))
        else $error("range completion mishandled");
    a_drive_limit: assert property (led_drive_code <= OCR_LED_MAX[4:0])
        else $error("drive code above limit");
    a_addr_ack: assert property (seq_addr_hit |=> !sda_oe_n && s.st == ST_AACK)
        else $error("own address not acknowledged");
endmodule : ocr_cmd_regs
`default_nettype wire

// ### core/ocr_cmd_regs_end.sv
// Intentionally minimal: no extra logic lives here.
// Assumes nothing.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### tb/ocr_host_model.sv
// Two-wire bus master standing in for the host controller of the register slice.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module ocr_host_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output var logic scl,
    output var logic host_low
);
    import ocr_pkg::*;
    initial begin
        scl = 1'h1;
        host_low = 1'h0;
    end
    // Changes land 1 ns after an edge; 4-cycle phases clear the 2-cycle minimum
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic put_bit(input logic b);
        host_low = ~b;
        cyc(4);
        scl = 1'h1;
        cyc(4);
        scl = 1'h0;
    endtask : put_bit
    // Sampled mid high phase, after the slave has settled its bit
    task automatic get_bit(output logic b);
        host_low = 1'h0;
        cyc(4);
        scl = 1'h1;
        cyc(2);
        b = sda_line;
        cyc(2);
        scl = 1'h0;
    endtask : get_bit
    // Also serves as repeated start from a low clock phase
    task automatic start();
        host_low = 1'h0;
        cyc(4);
        scl = 1'h1;
        cyc(4);
        host_low = 1'h1;
        cyc(4);
        scl = 1'h0;
    endtask : start
    task automatic stop();
        host_low = 1'h1;
        cyc(4);
        scl = 1'h1;
        cyc(4);
        host_low = 1'h0;
        cyc(4);
    endtask : stop
    // MSB first; ok drops if the ninth bit is not pulled low
    task automatic put_byte(input logic [7:0] d, inout logic ok);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ok = ok & ~b;
    endtask : put_byte
    task automatic probe(input logic [6:0] adr, output logic ok);
        ok = 1'h1;
        start();
        put_byte({adr, 1'h0}, ok);
        stop();
    endtask : probe
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        ok = 1'h1;
        start();
        put_byte({OCR_DEV_ADDR, 1'h0}, ok);
        put_byte(ptr, ok);
        put_byte(d, ok);
        stop();
    endtask : wr
    // Last byte is refused so the slave lets go of the line
    task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] d, output logic ok);
        logic b;
        ok = 1'h1;
        d = '0;
        start();
        put_byte({OCR_DEV_ADDR, 1'h0}, ok);
        put_byte(ptr, ok);
        start();
        put_byte({OCR_DEV_ADDR, 1'h1}, ok);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                get_bit(b);
                d = {d[14:0], b};
            end
            put_bit(k == n - 1);
        end
        stop();
    endtask : rd
endmodule : ocr_host_model
`default_nettype wire

// ### tb/ocr_cmd_regs_tb.sv
// Self-checking bench for the command register slice, with a conversion engine stand-in.
// Assumes the host model drives the bus and the pad pull-up is resolved here.
`timescale 1ns/10ps
`default_nettype none
module ocr_cmd_regs_tb;
    import ocr_pkg::*;
    localparam logic [7:0] PART = 8'h5C; // Arbitrary identification value
    localparam logic [1:0] TRIM = 2'h2; // Arbitrary trim program value
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic scl, host_low, sda_out, sda_oe_n, sda_line, ok;
    logic [2:0] light_avg_sel = 3'h0;
    ocr_conv_res_t light_conv = '0;
    ocr_conv_res_t range_conv = '0;
    logic light_conv_start, range_conv_start;
    logic [4:0] led_drive_code;
    logic [15:0] light_data = 16'h1234;
    logic [15:0] rd_val;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    int eng_delay = 1500;
    int n_light = 0;
    int n_range = 0;
    time light_t, range_t;
    // Pull-up wins unless a party pulls low
    assign sda_line = ~host_low & sda_oe_n;
    always #2 sys_clk = ~sys_clk;
    ocr_cmd_regs #(.PART_REV(PART), .TRIM_TAG(TRIM)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .light_avg_sel(light_avg_sel), .light_conv(light_conv), .range_conv(range_conv),
        .light_conv_start(light_conv_start), .range_conv_start(range_conv_start),
        .led_drive_code(led_drive_code));
    ocr_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .host_low(host_low));
    // Engine stand-ins; data is inverted outside the done pulse so stale values never pass
    always begin
        @(posedge sys_clk);
        if (light_conv_start === 1'h1) begin
            n_light++;
            light_t = $time;
            repeat (eng_delay) @(posedge sys_clk);
            #1 light_conv = '{done: 1'h1, data: light_data};
            @(posedge sys_clk);
            #1 light_conv = '{done: 1'h0, data: ~light_data};
            light_data += 16'h2;
        end
    end
    always begin
        @(posedge sys_clk);
        if (range_conv_start === 1'h1) begin
            n_range++;
            range_t = $time;
            repeat (eng_delay) @(posedge sys_clk);
            #1 range_conv = '{done: 1'h1, data: 16'h0A5C};
            @(posedge sys_clk);
            #1 range_conv = '{done: 1'h0, data: 16'hF5A3};
        end
    end
    // Whole run needs about 10k cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_chk(input logic [7:0] ptr, input logic [7:0] d);
        host.wr(ptr, d, ok);
        check(16'(ok), 16'h1);
    endtask : wr_chk
    task automatic rd_chk(input logic [7:0] ptr, input int n, input logic [15:0] exp);
        host.rd(ptr, n, rd_val, ok);
        check(16'(ok), 16'h1);
        check(rd_val, exp);
    endtask : rd_chk
    // Polls the command register a bounded number of times for the ready bits
    task automatic wait_rdy(input logic [7:0] mask);
        for (int i = 0; i < 12; i++) begin
            host.rd(OCR_REG_CMD, 1, rd_val, ok);
            if ((rd_val[7:0] & mask) === mask) break;
        end
    endtask : wait_rdy
    task automatic t_idle();
        rd_chk(OCR_REG_CMD, 1, 16'h0080);
        rd_chk(OCR_REG_ID, 1, 16'(PART));
        wr_chk(OCR_REG_ID, 8'h00);
        rd_chk(OCR_REG_ID, 1, 16'(PART));
        rd_chk(OCR_REG_SPARE, 1, 16'h0000);
        rd_chk(OCR_REG_LED, 1, 16'({TRIM, 6'h02}));
        check(16'(led_drive_code), 16'h0002);
        check(16'(sda_out), 16'h0000);
        host.probe(7'h12, ok);
        check(16'(ok), 16'h0);
    endtask : t_idle
    // Top bits written as zero must keep the trim tag
    task automatic t_led();
        logic [5:0] f[6] = '{6'h00, 6'h07, 6'h14, 6'h15, 6'h3F, 6'h02};
        foreach (f[i]) begin
            wr_chk(OCR_REG_LED, {2'h0, f[i]});
            host.cyc(2);
            check(16'(led_drive_code), (f[i] > 6'h14) ? 16'h0014 : 16'(f[i]));
            rd_chk(OCR_REG_LED, 1, 16'({TRIM, f[i]}));
        end
    endtask : t_led
    task automatic t_both();
        logic [15:0] e;
        e = light_data;
        eng_delay = 1500;
        wr_chk(OCR_REG_CMD, 8'h18);
        rd_chk(OCR_REG_CMD, 1, 16'h0098);
        check(16'(light_t == range_t), 16'h1);
        wait_rdy(8'h60);
        check(rd_val, 16'h00E0);
        rd_chk(OCR_REG_LIGHT_HI, 2, e);
        rd_chk(OCR_REG_CMD, 1, 16'h00A0);
        rd_chk(OCR_REG_RANGE_LO, 1, 16'h005C);
        rd_chk(OCR_REG_CMD, 1, 16'h0080);
        rd_chk(OCR_REG_RANGE_HI, 1, 16'h000A);
    endtask : t_both
    // Four samples spaced by 2 average to the first plus 3
    task automatic t_avg();
        logic [15:0] e;
        int n, nr;
        e = light_data + 16'h3;
        n = n_light;
        nr = n_range;
        eng_delay = 5;
        light_avg_sel = 3'h2;
        wr_chk(OCR_REG_CMD, 8'h10);
        wait_rdy(8'h40);
        check(16'(n_light - n), 16'h0004);
        check(16'(n_range - nr), 16'h0000);
        rd_chk(OCR_REG_LIGHT_LO, 1, 16'(e[7:0]));
        rd_chk(OCR_REG_CMD, 1, 16'h0080);
    endtask : t_avg
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'h1;
        host.cyc(2);
        t_idle();
        t_led();
        t_both();
        t_avg();
        stop_test();
    end
endmodule : ocr_cmd_regs_tb
`default_nettype wire
